/* File: trip_supervisor_defines.svh */
// Purpose: constants for the trip circuit supervisor
// Assumes: 10 MHz clock, 32-bit axi4-lite register bus
// Notes: all offsets are byte addresses
`ifndef TRIP_SUPERVISOR_DEFINES_SVH
`define TRIP_SUPERVISOR_DEFINES_SVH
`define CLK_HZ 10000000
`define QUERY_PERIOD_MS 500
`define QUERY_CYCLES ((`CLK_HZ / 1000) * `QUERY_PERIOD_MS)
`define FAULT_QUERIES 3
`define OFF_CONTROL 8'h00
`define OFF_STATUS 8'h04
`define OFF_IRQ_STATUS 8'h08
`define OFF_IRQ_ENABLE 8'h0c
`define OFF_IRQ_CLEAR 8'h10
`define CTRL_ENABLE_BIT 0
`define CTRL_MODE_BIT 1
`define CTRL_ALLOC_LO 2
`define CTRL_RESET 32'h00000000
`define IRQ_ALARM_SET 0
`define IRQ_ALARM_CLR 1
`define IRQ_MISMATCH 2
`define IRQ_WIDTH 3
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
`endif

/* File: trip_supervisor_pkg.sv */
// Purpose: types for the trip circuit supervisor
// Assumes: constants live in trip_supervisor_defines.svh
// Notes: none
package trip_supervisor_pkg;
  typedef enum logic [1:0] {
    mode_one_input = 2'h1,
    mode_two_input = 2'h2
  } mode_type;
  typedef struct packed {
    logic trip_contact;
    logic breaker_aux;
  } sense_type;
  typedef struct packed {
    logic alarm;
    logic mismatch;
    logic active;
  } status_type;
endpackage : trip_supervisor_pkg

/* File: sense_sync.sv */
// Purpose: two-flop synchroniser for the sensing pins
// Assumes: pins are asynchronous to clk_in
// Notes: first stage feeds only the second stage
module sense_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_stage2;

  always_comb begin
    next_stage1 = async_in;
    next_stage2 = stage1;
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end

  assign sync_out = stage2;
endmodule : sense_sync

/* File: trip_circuit_supervisor.sv */
// Purpose: trip circuit supervision through one or two sensing inputs, axi4-lite registers
// Assumes: sensing pins are high when energised, low when shorted by their contact
// Notes: alarm and its release are both debounced over the same number of queries
`include "trip_supervisor_defines.svh"

// Function
// - mode register bit selects one-input or two-input supervision.
// - allocation not matching selected mode raises the configuration mismatch output.
// - sensing input high means energised, low means shorted by its contact.
// - both inputs low briefly during a trip is a transient, no alarm.
// - persistent both-low state is the trip circuit fault criterion in two-input mode; in one-input mode the trip contact input low alone is.
// - both inputs are queried once every 500 ms.
// - alarm rises only after three consecutive faulty queries.
// - alarm clears after the same number of consecutive healthy queries.
// - enable bit defaults off; when off nothing is supervised or alarmed.
module trip_circuit_supervisor #(
  parameter int QUERY_CYCLES = `QUERY_CYCLES,
  parameter int FAULT_QUERIES = `FAULT_QUERIES
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic trip_contact_sense_input_in,
  input wire logic breaker_aux_sense_input_in,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic trip_circuit_alarm_out,
  output logic supervision_config_mismatch_out,
  output logic irq_out
);
  localparam int TW = $clog2(QUERY_CYCLES + 1);
  localparam int CW = $clog2(FAULT_QUERIES + 1);

  // ---------------- pin synchronisation
  logic [1:0] sense_raw;
  logic [1:0] sense_sync_q;
  trip_supervisor_pkg::sense_type sense;

  assign sense_raw = {trip_contact_sense_input_in, breaker_aux_sense_input_in};

  sense_sync #(.WIDTH(2)) u_sync (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .async_in(sense_raw),
    .sync_out(sense_sync_q)
  );

  // high level means energised, low means shorted by the contact
  assign sense = trip_supervisor_pkg::sense_type'(sense_sync_q);

  // ---------------- registers
  logic [31:0] control;
  logic [`IRQ_WIDTH-1:0] irq_status;
  logic [`IRQ_WIDTH-1:0] irq_enable;
  logic enable;
  logic mode_two;
  logic [1:0] alloc;
  trip_supervisor_pkg::mode_type mode;

  assign enable = control[`CTRL_ENABLE_BIT];
  assign mode_two = control[`CTRL_MODE_BIT];
  assign alloc = control[`CTRL_ALLOC_LO+1:`CTRL_ALLOC_LO];
  assign mode = mode_two ? trip_supervisor_pkg::mode_two_input
                         : trip_supervisor_pkg::mode_one_input;

  function automatic logic [1:0] inputs_needed(input trip_supervisor_pkg::mode_type m);
    inputs_needed = (m == trip_supervisor_pkg::mode_two_input) ? 2'h2 : 2'h1;
  endfunction : inputs_needed

  // ---------------- query timer
  logic [TW-1:0] tick_count;
  logic [TW-1:0] next_tick_count;
  logic query;

  always_comb begin
    next_tick_count = tick_count;
    query = 1'b0;
    if (!enable) begin
      next_tick_count = '0;
    end else if (tick_count == TW'(QUERY_CYCLES - 1)) begin
      next_tick_count = '0;
      query = 1'b1;
    end else begin
      next_tick_count = tick_count + TW'(1);
    end
  end

  // ---------------- debounce of the fault criterion
  logic fault_now;
  logic alarm;
  logic next_alarm;
  logic [CW-1:0] fault_count;
  logic [CW-1:0] next_fault_count;
  logic [CW-1:0] healthy_count;
  logic [CW-1:0] next_healthy_count;
  logic mismatch;
  logic alarm_rise;
  logic alarm_fall;

  // in one-input mode the lone input sits across the trip contact; low alone is the fault
  always_comb begin
    if (mode == trip_supervisor_pkg::mode_two_input) begin
      fault_now = !sense.trip_contact && !sense.breaker_aux;
    end else begin
      fault_now = !sense.trip_contact;
    end
  end

  assign mismatch = enable && (alloc != inputs_needed(mode));

  // a single low query never alarms, so a trip in progress passes unnoticed
  always_comb begin
    next_alarm = alarm;
    next_fault_count = fault_count;
    next_healthy_count = healthy_count;
    if (!enable || mismatch) begin
      next_alarm = 1'b0;
      next_fault_count = '0;
      next_healthy_count = '0;
    end else if (query) begin
      if (fault_now) begin
        next_healthy_count = '0;
        if (!alarm) begin
          if (fault_count == CW'(FAULT_QUERIES - 1)) begin
            next_alarm = 1'b1;
            next_fault_count = '0;
          end else begin
            next_fault_count = fault_count + CW'(1);
          end
        end
      end else begin
        next_fault_count = '0;
        if (alarm) begin
          if (healthy_count == CW'(FAULT_QUERIES - 1)) begin
            next_alarm = 1'b0;
            next_healthy_count = '0;
          end else begin
            next_healthy_count = healthy_count + CW'(1);
          end
        end
      end
    end
  end

  assign alarm_rise = next_alarm && !alarm;
  assign alarm_fall = !next_alarm && alarm;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      tick_count <= '0;
      alarm <= 1'b0;
      fault_count <= '0;
      healthy_count <= '0;
    end else begin
      tick_count <= next_tick_count;
      alarm <= next_alarm;
      fault_count <= next_fault_count;
      healthy_count <= next_healthy_count;
    end
  end

  // ---------------- axi4-lite slave
  logic aw_held;
  logic next_aw_held;
  logic [7:0] aw_addr;
  logic [7:0] next_aw_addr;
  logic w_held;
  logic next_w_held;
  logic [31:0] w_data;
  logic [31:0] next_w_data;
  logic [3:0] w_strb;
  logic [3:0] next_w_strb;
  logic bvalid;
  logic next_bvalid;
  logic [1:0] bresp;
  logic [1:0] next_bresp;
  logic rvalid;
  logic next_rvalid;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [1:0] rresp;
  logic [1:0] next_rresp;
  logic [31:0] next_control;
  logic [`IRQ_WIDTH-1:0] next_irq_status;
  logic [`IRQ_WIDTH-1:0] next_irq_enable;
  logic [`IRQ_WIDTH-1:0] irq_events;
  logic [`IRQ_WIDTH-1:0] irq_clear;
  logic do_write;
  logic mismatch_q;
  trip_supervisor_pkg::status_type status;

  assign s_axi_awready_out = !aw_held && !bvalid;
  assign s_axi_wready_out = !w_held && !bvalid;
  assign s_axi_arready_out = !rvalid;
  assign do_write = aw_held && w_held && !bvalid;
  assign status = '{alarm: alarm, mismatch: mismatch_q, active: enable && !mismatch_q};

  function automatic logic [31:0] apply_strobe(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    apply_strobe = r;
  endfunction : apply_strobe

  always_comb begin
    irq_events = '0;
    irq_events[`IRQ_ALARM_SET] = alarm_rise;
    irq_events[`IRQ_ALARM_CLR] = alarm_fall;
    irq_events[`IRQ_MISMATCH] = mismatch && !mismatch_q;
  end

  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_control = control;
    next_irq_enable = irq_enable;
    irq_clear = '0;
    if (s_axi_awvalid_in && s_axi_awready_out) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata_in;
      next_w_strb = s_axi_wstrb_in;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = `RESP_OKAY;
      if (aw_addr == `OFF_CONTROL) begin
        next_control = apply_strobe(control, w_data, w_strb) & 32'h0000000f;
      end else if (aw_addr == `OFF_IRQ_ENABLE) begin
        next_irq_enable = w_strb[0] ? w_data[`IRQ_WIDTH-1:0] : irq_enable;
      end else if (aw_addr == `OFF_IRQ_CLEAR) begin
        irq_clear = w_strb[0] ? w_data[`IRQ_WIDTH-1:0] : '0;
      end else if (aw_addr == `OFF_STATUS || aw_addr == `OFF_IRQ_STATUS) begin
        next_bresp = `RESP_OKAY;
      end else begin
        next_bresp = `RESP_DECERR;
      end
    end else if (bvalid && s_axi_bready_in) begin
      next_bvalid = 1'b0;
    end
    // a new event wins over a clear in the same cycle
    next_irq_status = (irq_status & ~irq_clear) | irq_events;
  end

  always_comb begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (s_axi_arvalid_in && s_axi_arready_out) begin
      next_rvalid = 1'b1;
      next_rresp = `RESP_OKAY;
      next_rdata = 32'h00000000;
      if (s_axi_araddr_in == `OFF_CONTROL) begin
        next_rdata = control;
      end else if (s_axi_araddr_in == `OFF_STATUS) begin
        next_rdata = {27'h0, sense.trip_contact, sense.breaker_aux, status};
      end else if (s_axi_araddr_in == `OFF_IRQ_STATUS) begin
        next_rdata = {29'h0, irq_status};
      end else if (s_axi_araddr_in == `OFF_IRQ_ENABLE) begin
        next_rdata = {29'h0, irq_enable};
      end else if (s_axi_araddr_in == `OFF_IRQ_CLEAR) begin
        next_rdata = 32'h00000000;
      end else begin
        next_rresp = `RESP_DECERR;
      end
    end else if (rvalid && s_axi_rready_in) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= 2'h0;
      control <= `CTRL_RESET;
      irq_status <= '0;
      irq_enable <= '0;
      mismatch_q <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      control <= next_control;
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
      mismatch_q <= mismatch;
    end
  end

  assign s_axi_bvalid_out = bvalid;
  assign s_axi_bresp_out = bresp;
  assign s_axi_rvalid_out = rvalid;
  assign s_axi_rdata_out = rdata;
  assign s_axi_rresp_out = rresp;
  assign trip_circuit_alarm_out = alarm;
  assign supervision_config_mismatch_out = mismatch_q;
  assign irq_out = |(irq_status & irq_enable);
endmodule : trip_circuit_supervisor

/* File: trip_circuit_model.sv */
// Purpose: breaker trip circuit seen through the two sensing pins
// Assumes: bench drives relay, breaker and wiring state after a clock edge
// Notes: a broken circuit carries no voltage, so both pins read low
module trip_circuit_model (
  input wire logic trip_cmd_in,
  input wire logic breaker_on_in,
  input wire logic broken_in,
  output logic trip_sense_out,
  output logic aux_sense_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // a closed contact shorts the pin wired across it
  always_comb begin
    trip_sense_out = !broken_in && !trip_cmd_in;
    aux_sense_out = !broken_in && !breaker_on_in;
  end
endmodule : trip_circuit_model

/* File: trip_supervisor_asserts.sv */
// Purpose: port checks for the trip circuit supervisor
// Assumes: one clock, synchronous active-low reset
// Notes: low_run cannot see the mode, so it bounds alarm rise only from below
`include "trip_supervisor_defines.svh"
module trip_supervisor_asserts #(
  parameter int QUERY_CYCLES = 10,
  parameter int FAULT_QUERIES = 3
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic trip_contact_sense_input_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic trip_circuit_alarm_out,
  input wire logic supervision_config_mismatch_out,
  input wire logic irq_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  int low_run;
  int next_low_run;
  always_comb begin
    next_low_run = trip_contact_sense_input_in ? 0 : low_run + 1;
  end
  always_ff @(posedge clk_in) begin
    low_run <= resetn_in ? next_low_run : 0;
  end
  a_reset_clear: assert property ($rose(resetn_in) |-> !trip_circuit_alarm_out && !irq_out)
    else $error("alarm or irq set after reset");
  a_rise_after_run: assert property ($rose(trip_circuit_alarm_out) |->
    low_run >= (FAULT_QUERIES - 1) * QUERY_CYCLES)
    else $error("alarm rose too early");
  a_mismatch_quiet: assert property (supervision_config_mismatch_out [*2] |-> !trip_circuit_alarm_out)
    else $error("alarm during mismatch");
  a_write_latency: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
    |-> ##1 !s_axi_bvalid_out ##1 s_axi_bvalid_out)
    else $error("write response late");
  a_read_latency: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read data late");
  a_r_release: assert property (s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out)
    else $error("rvalid held after accept");
  a_b_release: assert property (s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out)
    else $error("bvalid held after accept");
  a_b_busy: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out
    && s_axi_bresp_out inside {`RESP_OKAY, `RESP_DECERR})
    else $error("write channel open or bad bresp");
  a_ar_busy: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("arready during rvalid");
  c_alarm_up: cover property ($rose(trip_circuit_alarm_out));
  c_alarm_down: cover property ($fell(trip_circuit_alarm_out));
  c_mismatch: cover property ($rose(supervision_config_mismatch_out));
  c_irq: cover property ($rose(irq_out));
endmodule : trip_supervisor_asserts
bind trip_circuit_supervisor trip_supervisor_asserts #(.QUERY_CYCLES(QUERY_CYCLES), .FAULT_QUERIES(FAULT_QUERIES))
  chk_i (.clk_in, .resetn_in, .trip_contact_sense_input_in, .s_axi_awvalid_in, .s_axi_awready_out,
  .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
  .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rvalid_out, .s_axi_rready_in, .trip_circuit_alarm_out,
  .supervision_config_mismatch_out, .irq_out);

/* File: tb_top.sv */
// Purpose: self-checking bench for the trip circuit supervisor
// Assumes: query period shortened to QC clocks
// Notes: fault windows are whole query periods so query counts are exact
`include "trip_supervisor_defines.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int QC = 10;
  logic clk_in = 0;
  logic resetn_in = 0;
  logic trip_cmd = 0;
  logic brk_on = 1;
  logic broken = 0;
  logic awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic trip_s, aux_s, awready, wready, bvalid, arready, rvalid, alarm, mism, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int fail_count = 0;
  int comparisons = 0;
  trip_circuit_model part (.trip_cmd_in(trip_cmd), .breaker_on_in(brk_on), .broken_in(broken),
    .trip_sense_out(trip_s), .aux_sense_out(aux_s));
  trip_circuit_supervisor #(.QUERY_CYCLES(QC)) uut (.clk_in(clk_in), .resetn_in(resetn_in),
    .trip_contact_sense_input_in(trip_s), .breaker_aux_sense_input_in(aux_s),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .trip_circuit_alarm_out(alarm), .supervision_config_mismatch_out(mism), .irq_out(irq));
  initial begin
    forever #50 clk_in = ~clk_in;
  end
  task automatic test_done();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask : cyc
  // a stuck slave leaves the response at 2, which no expectation uses
  task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic [1:0] r;
    logic done;
    n = 0;
    done = 1'b0;
    r = 2'h2;
    @(posedge clk_in);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    // a local flag, since the ready strobe raised above is not yet visible here
    while (!done && n < 40) begin
      @(posedge clk_in);
      n++;
      if (awready) awv <= 1'b0;
      if (wready) wv <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    chk(32'(r), 32'(er));
  endtask : wrc
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    logic [1:0] r;
    logic [31:0] d;
    logic done;
    n = 0;
    done = 1'b0;
    r = 2'h2;
    d = 32'h0;
    @(posedge clk_in);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    while (!done && n < 40) begin
      @(posedge clk_in);
      n++;
      if (arready) arv <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    chk(d, e);
    chk(32'(r), 32'(er));
  endtask : rchk
  task automatic t_reset();
    rchk(`OFF_CONTROL, 32'h0, `RESP_OKAY);
    chk(32'(alarm), 32'h0);
    chk(32'(irq), 32'h0);
    broken <= 1'b1;
    cyc(5 * QC);
    chk(32'(alarm), 32'h0);
    broken <= 1'b0;
  endtask : t_reset
  task automatic t_bus();
    rchk(8'h40, 32'h0, `RESP_DECERR);
    wrc(8'h40, 32'hffffffff, `RESP_DECERR);
    wrc(`OFF_STATUS, 32'hffffffff, `RESP_OKAY);
    rchk(`OFF_STATUS, 32'h10, `RESP_OKAY);
  endtask : t_bus
  task automatic t_two_input();
    wrc(`OFF_CONTROL, 32'h0b, `RESP_OKAY);
    wrc(`OFF_IRQ_ENABLE, 32'h1, `RESP_OKAY);
    trip_cmd <= 1'b1;
    cyc(2 * QC);
    trip_cmd <= 1'b0;
    brk_on <= 1'b0;
    cyc(QC);
    brk_on <= 1'b1;
    trip_cmd <= 1'b1;
    cyc(2 * QC);
    trip_cmd <= 1'b0;
    cyc(QC + 5);
    chk(32'(alarm), 32'h0);
    broken <= 1'b1;
    cyc(2 * QC - 1);
    chk(32'(alarm), 32'h0);
    cyc(QC + 5);
    chk(32'(alarm), 32'h1);
    chk(32'(irq), 32'h1);
    broken <= 1'b0;
    cyc(2 * QC - 1);
    chk(32'(alarm), 32'h1);
    cyc(QC + 5);
    chk(32'(alarm), 32'h0);
    wrc(`OFF_IRQ_CLEAR, 32'h1, `RESP_OKAY);
    chk(32'(irq), 32'h0);
    rchk(`OFF_IRQ_STATUS, 32'h2, `RESP_OKAY);
  endtask : t_two_input
  task automatic t_mismatch();
    wrc(`OFF_CONTROL, 32'h07, `RESP_OKAY);
    cyc(2);
    chk(32'(mism), 32'h1);
    rchk(`OFF_STATUS, 32'h12, `RESP_OKAY);
    wrc(`OFF_IRQ_ENABLE, 32'h4, `RESP_OKAY);
    chk(32'(irq), 32'h1);
    wrc(`OFF_IRQ_CLEAR, 32'h4, `RESP_OKAY);
    chk(32'(irq), 32'h0);
  endtask : t_mismatch
  task automatic t_one_input();
    wrc(`OFF_CONTROL, 32'h05, `RESP_OKAY);
    cyc(2);
    chk(32'(mism), 32'h0);
    brk_on <= 1'b0;
    trip_cmd <= 1'b1;
    cyc(3 * QC + 4);
    chk(32'(alarm), 32'h1);
    wrc(`OFF_CONTROL, 32'h01, `RESP_OKAY);
    cyc(2);
    chk(32'(alarm), 32'h0);
    wrc(`OFF_CONTROL, 32'h05, `RESP_OKAY);
    cyc(3 * QC + 4);
    chk(32'(alarm), 32'h1);
    wrc(`OFF_CONTROL, 32'h0, `RESP_OKAY);
    cyc(2);
    chk(32'(alarm), 32'h0);
    trip_cmd <= 1'b0;
    brk_on <= 1'b1;
  endtask : t_one_input
  initial begin
    repeat (12) @(posedge clk_in);
    resetn_in <= 1'b1;
    t_reset();
    t_bus();
    t_two_input();
    t_mismatch();
    t_one_input();
    test_done();
  end
  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_in);
    fail_count++;
    test_done();
  end
endmodule : tb_top
